// *** inc_skip_or_pkg.sv ***
// constants, types and register map for the increment-skip / or execution block
`default_nettype none
package inc_skip_or_pkg;

  // ==========================================================
  // widths
  localparam int unsigned INSTR_W = 16;
  localparam int unsigned DATA_W  = 8;
  localparam int unsigned FILE_W  = 8;
  localparam int unsigned ADDR_W  = 12;
  localparam int unsigned BANK_W  = 4;
  localparam int unsigned APB_AW  = 12;

  // ==========================================================
  // opcodes and instruction fields
  localparam logic [5:0] OPC_INC_SKIP_NZ = 6'h12;
  localparam logic [5:0] OPC_INC_SKIP_Z  = 6'h0f;
  localparam logic [5:0] OPC_OR_FILE     = 6'h04;
  localparam logic [7:0] OPC_OR_LIT      = 8'h09;
  localparam int unsigned OPC6_LSB       = 10;
  localparam int unsigned OPC8_LSB       = 8;
  localparam int unsigned DEST_BIT       = 9;
  localparam int unsigned BANK_SEL_BIT   = 8;

  // ==========================================================
  // operand addressing
  localparam logic [FILE_W-1:0] INDEXED_LIMIT   = 8'h5f;
  localparam logic [BANK_W-1:0] ACCESS_LOW_BANK = 4'h0;
  localparam logic [BANK_W-1:0] ACCESS_HI_BANK  = 4'hf;

  // ==========================================================
  // timing
  localparam logic [1:0] PHASE_Q1    = 2'h0;
  localparam logic [1:0] PHASE_Q2    = 2'h1;
  localparam logic [1:0] PHASE_Q3    = 2'h2;
  localparam logic [1:0] PHASE_Q4    = 2'h3;
  localparam logic [1:0] NOP_ONE     = 2'h1;
  localparam logic [1:0] NOP_TWO     = 2'h2;

  // ==========================================================
  // register offsets and fields
  localparam logic [APB_AW-1:0] ADDR_CTRL   = 12'h000;
  localparam logic [APB_AW-1:0] ADDR_BANK   = 12'h004;
  localparam logic [APB_AW-1:0] ADDR_INDEX  = 12'h008;
  localparam logic [APB_AW-1:0] ADDR_ACC    = 12'h00c;
  localparam logic [APB_AW-1:0] ADDR_STATUS = 12'h010;
  localparam int unsigned CTRL_EXT_BIT  = 0;
  localparam int unsigned STAT_Z_BIT    = 0;
  localparam int unsigned STAT_N_BIT    = 1;
  localparam int unsigned STAT_BUSY_BIT = 2;
  localparam int unsigned STAT_SKIP_BIT = 3;
  localparam int unsigned STAT_UNSUP_BIT = 4;
  localparam logic              CTRL_RST  = 1'b0;
  localparam logic [BANK_W-1:0] BANK_RST  = 4'h0;
  localparam logic [ADDR_W-1:0] INDEX_RST = 12'h000;
  localparam logic [DATA_W-1:0] ACC_RST   = 8'h00;

  // ==========================================================
  // types
  typedef enum logic [2:0] {op_none, op_inc_skip_nz, op_inc_skip_z, op_or_lit, op_or_file} op_e;
  typedef enum logic [1:0] {st_idle, st_exec, st_nop} state_e;

  typedef struct packed {
    logic              rd_en;
    logic              wr_en;
    logic [ADDR_W-1:0] addr;
    logic [DATA_W-1:0] wdata;
  } mem_req_s;

  typedef struct packed {
    logic               valid;
    logic [INSTR_W-1:0] word;
    logic               next_two_word;
  } fetch_s;

endpackage
`default_nettype wire

// *** inc_skip_or_exec.sv ***
// execution logic for increment-and-skip and inclusive-or instructions, with apb control
//
// Behaviour
// - increment-skip-if-nonzero reads the file register, adds one and sends the sum to the destination.
// - a nonzero increment-skip-if-nonzero result discards the prefetched instruction and runs a nop cycle.
// - destination bit clear sends the result to the accumulator, set sends it back to the file register.
// - bank bit clear addresses the operand in the quick access bank, ignoring the bank pointer register.
// - bank bit set takes the bank from the bank pointer register.
// - with extended set enabled, bank bit clear and file address at most 95, indexed literal offset is used.
// - a skip instruction takes one cycle, two when skipping, three when skipping a two-word instruction.
// - each extra skip cycle is a full four-phase nop, two of them for a two-word skipped instruction.
// - or-literal ors the accumulator with the 8-bit literal and writes the accumulator.
// - the or operations update only the negative and zero flags.
// - or-file ors the accumulator with the file register, honouring destination and bank bits.
// - increment-skip-if-zero increments the file register and skips on a zero result.
//
// Design decisions made here: the address map and register access over APB.
`default_nettype none
module inc_skip_or_exec #(
  parameter int unsigned BANK_BITS = inc_skip_or_pkg::BANK_W
) (
  // clock and reset
  input  wire logic                                 pclk,
  input  wire logic                                 presetn,
  // apb slave
  input  wire logic                                 psel,
  input  wire logic                                 penable,
  input  wire logic                                 pwrite,
  input  wire logic [inc_skip_or_pkg::APB_AW-1:0]   paddr,
  input  wire logic [31:0]                          pwdata,
  output var  logic [31:0]                          prdata,
  output var  logic                                 pready,
  output var  logic                                 pslverr,
  // instruction fetch
  input  wire inc_skip_or_pkg::fetch_s              fetch,
  output var  logic                                 fetch_ready,
  output var  logic                                 discard_prefetch,
  output var  logic                                 instr_done,
  // data memory
  output var  inc_skip_or_pkg::mem_req_s            mem_req,
  input  wire logic [inc_skip_or_pkg::DATA_W-1:0]   mem_rdata,
  // core state
  output var  logic [inc_skip_or_pkg::DATA_W-1:0]   accumulator,
  output var  logic                                 flag_negative,
  output var  logic                                 flag_zero
);
  import inc_skip_or_pkg::*;

  // ==========================================================
  // elaboration check
  if (BANK_BITS + FILE_W != ADDR_W) begin : g_bad_bank
    $error("bank pointer width must fill the data address");
  end

  // ==========================================================
  // state
  state_e              state_reg;
  logic [1:0]          phase_reg;
  logic [1:0]          nop_left_reg;
  op_e                 op_reg;
  logic [INSTR_W-1:0]  instr_reg;
  logic                two_word_reg;
  logic [DATA_W-1:0]   result_reg;
  logic [DATA_W-1:0]   acc_reg;
  logic                flag_n_reg;
  logic                flag_z_reg;
  logic                ext_reg;
  logic [BANK_W-1:0]   bank_reg;
  logic [ADDR_W-1:0]   index_reg;
  logic                skip_seen_reg;
  logic                unsup_reg;
  mem_req_s            mem_req_reg;
  logic                fetch_ready_reg;
  logic                discard_reg;
  logic                done_reg;
  logic [31:0]         prdata_reg;
  logic                pready_reg;
  logic                pslverr_reg;

  // ==========================================================
  // decode helpers
  function automatic op_e op_decode(input logic [INSTR_W-1:0] w);
    op_e op;
    op = op_none;
    if (w[INSTR_W-1:OPC6_LSB] == OPC_INC_SKIP_NZ) begin
      op = op_inc_skip_nz;
    end else if (w[INSTR_W-1:OPC6_LSB] == OPC_INC_SKIP_Z) begin
      op = op_inc_skip_z;
    end else if (w[INSTR_W-1:OPC6_LSB] == OPC_OR_FILE) begin
      op = op_or_file;
    end else if (w[INSTR_W-1:OPC8_LSB] == OPC_OR_LIT) begin
      op = op_or_lit;
    end
    return op;
  endfunction

  function automatic logic is_file_op(input op_e op);
    return (op == op_inc_skip_nz) || (op == op_inc_skip_z) || (op == op_or_file);
  endfunction

  function automatic logic [ADDR_W-1:0] operand_addr(input logic [INSTR_W-1:0] w, input logic ext,
                                                    input logic [BANK_W-1:0] bank,
                                                    input logic [ADDR_W-1:0] base);
    logic [FILE_W-1:0] f;
    logic [ADDR_W-1:0] a;
    f = w[FILE_W-1:0];
    if (w[BANK_SEL_BIT]) begin
      a = {bank, f};
    end else if (ext && (f <= INDEXED_LIMIT)) begin
      a = ADDR_W'(base + {{(ADDR_W-FILE_W){1'b0}}, f});
    end else if (f <= INDEXED_LIMIT) begin
      a = {ACCESS_LOW_BANK, f};
    end else begin
      a = {ACCESS_HI_BANK, f};
    end
    return a;
  endfunction

  function automatic logic reg_mapped(input logic [APB_AW-1:0] a);
    return (a == ADDR_CTRL) || (a == ADDR_BANK) || (a == ADDR_INDEX) ||
           (a == ADDR_ACC) || (a == ADDR_STATUS);
  endfunction

  // ==========================================================
  // combinational terms
  logic take;
  logic skip_now;
  logic dest_file;
  logic apb_wr;
  logic core_acc_wr;
  logic core_flag_wr;

  assign take      = (state_reg == st_idle) && fetch.valid && fetch_ready_reg;
  assign dest_file = instr_reg[DEST_BIT];
  assign skip_now  = ((op_reg == op_inc_skip_nz) && (result_reg != 8'h00)) ||
                     ((op_reg == op_inc_skip_z) && (result_reg == 8'h00));
  assign apb_wr    = psel && penable && pready_reg && pwrite && !pslverr_reg;
  assign core_acc_wr  = (state_reg == st_exec) && (phase_reg == PHASE_Q4) &&
                        ((op_reg == op_or_lit) || (is_file_op(op_reg) && !dest_file));
  assign core_flag_wr = (state_reg == st_exec) && (phase_reg == PHASE_Q4) &&
                        ((op_reg == op_or_lit) || (op_reg == op_or_file));

  // ==========================================================
  // sequencing: four phases per cycle, then optional nop cycles
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state_reg    <= st_idle;
      phase_reg    <= PHASE_Q1;
      nop_left_reg <= 2'h0;
    end else begin
      case (state_reg)
        st_idle: begin
          if (take) begin
            state_reg <= st_exec;
            phase_reg <= PHASE_Q1;
          end
        end
        st_exec: begin
          phase_reg <= phase_reg + 2'h1;
          if (phase_reg == PHASE_Q4) begin
            if (skip_now) begin
              state_reg    <= st_nop;
              nop_left_reg <= two_word_reg ? NOP_TWO : NOP_ONE;
            end else begin
              state_reg <= st_idle;
            end
          end
        end
        st_nop: begin
          phase_reg <= phase_reg + 2'h1;
          if (phase_reg == PHASE_Q4) begin
            if (nop_left_reg == NOP_ONE) begin
              state_reg <= st_idle;
            end
            nop_left_reg <= nop_left_reg - 2'h1;
          end
        end
        default: begin
          state_reg <= st_idle;
          phase_reg <= PHASE_Q1;
        end
      endcase
    end
  end

  // ==========================================================
  // instruction capture
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      instr_reg    <= 16'h0000;
      op_reg       <= op_none;
      two_word_reg <= 1'b0;
    end else if (take) begin
      instr_reg    <= fetch.word;
      op_reg       <= op_decode(fetch.word);
      two_word_reg <= fetch.next_two_word;
    end
  end

  // ==========================================================
  // fetch handshake and completion pulses
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      fetch_ready_reg <= 1'b1;
      discard_reg     <= 1'b0;
      done_reg        <= 1'b0;
    end else begin
      discard_reg <= (state_reg == st_exec) && (phase_reg == PHASE_Q4) && skip_now;
      done_reg    <= 1'b0;
      if (take) begin
        fetch_ready_reg <= 1'b0;
      end else if ((state_reg == st_exec) && (phase_reg == PHASE_Q4) && !skip_now) begin
        fetch_ready_reg <= 1'b1;
        done_reg        <= 1'b1;
      end else if ((state_reg == st_nop) && (phase_reg == PHASE_Q4) && (nop_left_reg == NOP_ONE)) begin
        fetch_ready_reg <= 1'b1;
        done_reg        <= 1'b1;
      end
    end
  end

  // ==========================================================
  // data memory: read in q2, write after q4
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      mem_req_reg <= '0;
    end else begin
      mem_req_reg.rd_en <= 1'b0;
      mem_req_reg.wr_en <= 1'b0;
      if ((state_reg == st_exec) && (phase_reg == PHASE_Q1)) begin
        mem_req_reg.addr  <= operand_addr(instr_reg, ext_reg, bank_reg, index_reg);
        mem_req_reg.rd_en <= is_file_op(op_reg);
      end
      if ((state_reg == st_exec) && (phase_reg == PHASE_Q4) && is_file_op(op_reg) && dest_file) begin
        mem_req_reg.wr_en <= 1'b1;
        mem_req_reg.wdata <= result_reg;
      end
    end
  end

  // ==========================================================
  // process data in q3
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      result_reg <= 8'h00;
    end else if ((state_reg == st_exec) && (phase_reg == PHASE_Q3)) begin
      case (op_reg)
        op_inc_skip_nz: result_reg <= mem_rdata + 8'h01;
        op_inc_skip_z:  result_reg <= mem_rdata + 8'h01;
        op_or_lit:      result_reg <= acc_reg | instr_reg[DATA_W-1:0];
        op_or_file:     result_reg <= acc_reg | mem_rdata;
        default:        result_reg <= result_reg;
      endcase
    end
  end

  // ==========================================================
  // accumulator and flags; the core write wins over software
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      acc_reg <= ACC_RST;
    end else if (core_acc_wr) begin
      acc_reg <= result_reg;
    end else if (apb_wr && (paddr == ADDR_ACC)) begin
      acc_reg <= pwdata[DATA_W-1:0];
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      flag_n_reg <= 1'b0;
      flag_z_reg <= 1'b0;
    end else if (core_flag_wr) begin
      flag_n_reg <= result_reg[DATA_W-1];
      flag_z_reg <= (result_reg == 8'h00);
    end else if (apb_wr && (paddr == ADDR_STATUS)) begin
      flag_n_reg <= pwdata[STAT_N_BIT];
      flag_z_reg <= pwdata[STAT_Z_BIT];
    end
  end

  // ==========================================================
  // sticky status: hardware set wins over a software clear
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      skip_seen_reg <= 1'b0;
      unsup_reg     <= 1'b0;
    end else begin
      if ((state_reg == st_exec) && (phase_reg == PHASE_Q4) && skip_now) begin
        skip_seen_reg <= 1'b1;
      end else if (apb_wr && (paddr == ADDR_STATUS) && pwdata[STAT_SKIP_BIT]) begin
        skip_seen_reg <= 1'b0;
      end
      if ((state_reg == st_exec) && (phase_reg == PHASE_Q1) && (op_reg == op_none)) begin
        unsup_reg <= 1'b1;
      end else if (apb_wr && (paddr == ADDR_STATUS) && pwdata[STAT_UNSUP_BIT]) begin
        unsup_reg <= 1'b0;
      end
    end
  end

  // ==========================================================
  // control registers
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ext_reg   <= CTRL_RST;
      bank_reg  <= BANK_RST;
      index_reg <= INDEX_RST;
    end else if (apb_wr) begin
      if (paddr == ADDR_CTRL) begin
        ext_reg <= pwdata[CTRL_EXT_BIT];
      end
      if (paddr == ADDR_BANK) begin
        bank_reg <= pwdata[BANK_W-1:0];
      end
      if (paddr == ADDR_INDEX) begin
        index_reg <= pwdata[ADDR_W-1:0];
      end
    end
  end

  // ==========================================================
  // apb slave: one wait-free access cycle after setup
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready_reg  <= 1'b0;
      pslverr_reg <= 1'b0;
      prdata_reg  <= 32'h0000_0000;
    end else if (psel && !penable) begin
      pready_reg  <= 1'b1;
      pslverr_reg <= !reg_mapped(paddr);
      prdata_reg  <= 32'h0000_0000;
      if (!pwrite) begin
        case (paddr)
          ADDR_CTRL:   prdata_reg[CTRL_EXT_BIT] <= ext_reg;
          ADDR_BANK:   prdata_reg[BANK_W-1:0]   <= bank_reg;
          ADDR_INDEX:  prdata_reg[ADDR_W-1:0]   <= index_reg;
          ADDR_ACC:    prdata_reg[DATA_W-1:0]   <= acc_reg;
          ADDR_STATUS: begin
            prdata_reg[STAT_Z_BIT]     <= flag_z_reg;
            prdata_reg[STAT_N_BIT]     <= flag_n_reg;
            prdata_reg[STAT_BUSY_BIT]  <= (state_reg != st_idle);
            prdata_reg[STAT_SKIP_BIT]  <= skip_seen_reg;
            prdata_reg[STAT_UNSUP_BIT] <= unsup_reg;
          end
          default:     prdata_reg <= 32'h0000_0000;
        endcase
      end
    end else begin
      pready_reg  <= 1'b0;
      pslverr_reg <= 1'b0;
    end
  end

  // ==========================================================
  // outputs
  assign prdata           = prdata_reg;
  assign pready           = pready_reg;
  assign pslverr          = pslverr_reg;
  assign fetch_ready      = fetch_ready_reg;
  assign discard_prefetch = discard_reg;
  assign instr_done       = done_reg;
  assign mem_req          = mem_req_reg;
  assign accumulator      = acc_reg;
  assign flag_negative    = flag_n_reg;
  assign flag_zero        = flag_z_reg;

endmodule // inc_skip_or_exec
`default_nettype wire

// *** data_mem_model.sv ***
// synchronous data memory model on the far side of the execution block
`default_nettype none
module data_mem_model (
  // clock
  input  wire logic                               pclk,
  // request and answer
  input  wire inc_skip_or_pkg::mem_req_s          mem_req,
  output var  logic [inc_skip_or_pkg::DATA_W-1:0] mem_rdata
);
  timeunit 1ns;
  timeprecision 1ns;
  import inc_skip_or_pkg::*;
  // ==========
  // storage
  logic [DATA_W-1:0] mem [0:4095];
  logic [DATA_W-1:0] last_q = 8'h00;
  logic              live_q = 1'b0;
  always @(posedge pclk) begin
    live_q <= mem_req.rd_en;
    if (mem_req.rd_en) begin
      last_q <= mem[mem_req.addr];
    end
    if (mem_req.wr_en) begin
      mem[mem_req.addr] <= mem_req.wdata;
    end
  end
  // read data is valid for one cycle only, then shows the inverse
  assign mem_rdata = live_q ? last_q : ~last_q;
endmodule // data_mem_model
`default_nettype wire

// *** inc_skip_or_properties.sv ***
// port-level assertions for the increment-skip / or execution block
`default_nettype none
module inc_skip_or_properties #(
  parameter int unsigned BANK_BITS = 4
) (
  // clock and reset
  input wire logic                               pclk,
  input wire logic                               presetn,
  // apb
  input wire logic                               psel,
  input wire logic                               penable,
  input wire logic                               pready,
  // fetch
  input wire inc_skip_or_pkg::fetch_s            fetch,
  input wire logic                               fetch_ready,
  input wire logic                               discard_prefetch,
  input wire logic                               instr_done,
  // memory and core state
  input wire inc_skip_or_pkg::mem_req_s          mem_req,
  input wire logic [inc_skip_or_pkg::DATA_W-1:0] mem_rdata,
  input wire logic [inc_skip_or_pkg::DATA_W-1:0] accumulator,
  input wire logic                               flag_negative,
  input wire logic                               flag_zero
);
  timeunit 1ns;
  timeprecision 1ns;
  import inc_skip_or_pkg::*;
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  // ==========
  // helper state
  logic              take, inc_op, file_op, rd_q, inc_q, two_q, dst_q;
  logic [5:0]        opc;
  logic [DATA_W-1:0] rdat_q, acc_q, lit_q;
  assign take = fetch.valid && fetch_ready;
  assign opc = fetch.word[15:10];
  assign inc_op = opc == OPC_INC_SKIP_NZ || opc == OPC_INC_SKIP_Z;
  assign file_op = inc_op || opc == OPC_OR_FILE;
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      {rd_q, inc_q, two_q, dst_q} <= 4'h0;
      {rdat_q, acc_q, lit_q} <= 24'h000000;
    end else begin
      rd_q <= mem_req.rd_en;
      if (rd_q) begin
        rdat_q <= mem_rdata;
      end
      if (take) begin
        {inc_q, two_q, dst_q} <= {inc_op, fetch.next_two_word, fetch.word[9]};
        {acc_q, lit_q} <= {accumulator, fetch.word[7:0]};
      end
    end
  end
  // ==========
  // assertions
  AST_APB_ONE_WAIT: assert property (psel && !penable |=> pready ##1 !pready)
    else $error("pready not in first access cycle");
  AST_READ_PHASE: assert property (take && file_op |-> ##2 mem_req.rd_en ##1 !mem_req.rd_en)
    else $error("operand read not in second phase");
  AST_INC_SUM: assert property (mem_req.wr_en && inc_q |-> mem_req.wdata == rdat_q + 8'h01)
    else $error("increment result wrong");
  AST_DEST_SEL: assert property (take && file_op |-> ##5 mem_req.wr_en == dst_q)
    else $error("destination select not honoured");
  AST_SKIP_NZ: assert property (take && opc == OPC_INC_SKIP_NZ
    |-> ##5 discard_prefetch == (rdat_q + 8'h01 != 8'h00))
    else $error("skip on nonzero wrong");
  AST_SKIP_Z: assert property (take && opc == OPC_INC_SKIP_Z
    |-> ##5 discard_prefetch == (rdat_q + 8'h01 == 8'h00))
    else $error("skip on zero wrong");
  AST_FIRST_CYCLE: assert property (take |-> ##5 instr_done != discard_prefetch)
    else $error("first cycle neither done nor skipping");
  AST_SKIP_LEN: assert property (discard_prefetch |->
    if (two_q) ##4 !instr_done ##4 instr_done else ##4 instr_done)
    else $error("skip cycle count wrong");
  AST_NOP_QUIET: assert property (discard_prefetch |=> !(mem_req.rd_en || mem_req.wr_en) [*3])
    else $error("memory activity in nop cycle");
  AST_OR_LIT: assert property (take && fetch.word[15:8] == OPC_OR_LIT
    |-> ##5 accumulator == (acc_q | lit_q) && flag_zero == (accumulator == 8'h00))
    else $error("or literal result wrong");
  // flags follow the or result, wherever the destination bit sent it
  AST_OR_NEG: assert property (take && (opc == OPC_OR_FILE || fetch.word[15:8] == OPC_OR_LIT)
    |-> ##5 flag_negative == (dst_q ? mem_req.wdata[7] : accumulator[7]) &&
        flag_zero == ((dst_q ? mem_req.wdata : accumulator) == 8'h00))
    else $error("or flags wrong");
  AST_INC_FLAGS: assert property (take && inc_op |=> $stable({flag_negative, flag_zero}) [*5])
    else $error("increment changed a flag");
endmodule // inc_skip_or_properties
bind inc_skip_or_exec inc_skip_or_properties #(.BANK_BITS(BANK_BITS)) i_props (
  .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pready(pready),
  .fetch(fetch), .fetch_ready(fetch_ready), .discard_prefetch(discard_prefetch),
  .instr_done(instr_done), .mem_req(mem_req), .mem_rdata(mem_rdata),
  .accumulator(accumulator), .flag_negative(flag_negative), .flag_zero(flag_zero));
`default_nettype wire

// *** tb_inc_skip_or_exec.sv ***
// self-checking bench for the increment-skip / or execution block
`default_nettype none
module tb_inc_skip_or_exec;
  timeunit 1ns;
  timeprecision 1ns;
  import inc_skip_or_pkg::*;
  logic              pclk, presetn, psel, penable, pwrite, pready, pslverr;
  logic              fetch_ready, discard_prefetch, instr_done, flag_negative, flag_zero;
  logic [APB_AW-1:0] paddr;
  logic [31:0]       pwdata, prdata;
  logic [DATA_W-1:0] accumulator, mem_rdata;
  fetch_s            fetch;
  mem_req_s          mem_req;
  int                miscompares = 0, checks = 0, ndisc = 0;
  inc_skip_or_exec #(.BANK_BITS(4)) i_dut (.pclk(pclk), .presetn(presetn), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .fetch(fetch), .fetch_ready(fetch_ready),
    .discard_prefetch(discard_prefetch), .instr_done(instr_done), .mem_req(mem_req),
    .mem_rdata(mem_rdata), .accumulator(accumulator), .flag_negative(flag_negative),
    .flag_zero(flag_zero));
  data_mem_model i_mem (.pclk(pclk), .mem_req(mem_req), .mem_rdata(mem_rdata));
  initial begin
    pclk = 1'b0;
    forever #50 pclk = ~pclk;
  end
  always @(posedge pclk) if (discard_prefetch === 1'b1) ndisc <= ndisc + 1;
  // ==========
  // compare and bus tasks
  task automatic chk(input string what, input logic [31:0] e, input logic [31:0] g);
    checks++;
    if (g !== e) begin
      miscompares++;
      $display("Error %s expected %h seen %h", what, e, g);
    end
  endtask
  task automatic chk_cnt(input string what, input int e, input int g);
    checks++;
    if (g != e) begin
      miscompares++;
      $display("Error %s expected %0d seen %0d", what, e, g);
    end
  endtask
  task automatic apb(input logic w, input logic [APB_AW-1:0] a, input logic [31:0] d,
                     output logic [31:0] q, output logic err);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do @(posedge pclk); while (pready !== 1'b1);
    q = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge pclk);
  endtask
  task automatic wr(input logic [APB_AW-1:0] a, input logic [31:0] d);
    logic [31:0] q;
    logic        err;
    apb(1'b1, a, d, q, err);
  endtask
  task automatic rchk(input logic [APB_AW-1:0] a, input logic [31:0] e, input logic ee);
    logic [31:0] q;
    logic        err;
    apb(1'b0, a, 32'h0, q, err);
    chk("prdata", e, q);
    chk("pslverr", ee, err);
  endtask
  // issue one instruction and count pclk edges until done
  task automatic op(input logic [15:0] w, input logic tw, input int cyc, input int sk);
    int n, d0;
    d0 = ndisc;
    fetch <= '{1'b1, w, tw};
    do @(posedge pclk); while (fetch_ready !== 1'b1);
    fetch.valid <= 1'b0;
    n = 0;
    do begin
      @(posedge pclk);
      n++;
    end while (instr_done !== 1'b1);
    @(posedge pclk);
    chk_cnt("cycles", 4 * cyc + 1, n);
    chk_cnt("skips", sk, ndisc - d0);
  endtask
  task automatic report_and_stop();
    if (miscompares == 0 && checks > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask
  initial begin
    repeat (3000) @(posedge pclk);
    miscompares++;
    report_and_stop();
  end
  // ==========
  // tests
  initial begin
    {presetn, psel, penable, pwrite, paddr, pwdata} = '0;
    fetch = '0;
    repeat (8) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    rchk(ADDR_ACC, 32'h0, 1'b0);
    rchk(12'h020, 32'h0, 1'b1);
    wr(ADDR_BANK, 32'h3);
    rchk(ADDR_BANK, 32'h3, 1'b0);
    wr(ADDR_INDEX, 32'h200);
    wr(ADDR_STATUS, 32'h2);
    i_mem.mem[12'h310] = 8'h41;
    op({OPC_INC_SKIP_NZ, 2'b11, 8'h10}, 1'b0, 2, 1);
    chk("mem", 8'h42, i_mem.mem[12'h310]);
    chk("flags", 2'b10, {flag_negative, flag_zero});
    rchk(ADDR_STATUS, 32'ha, 1'b0);
    wr(ADDR_STATUS, 32'ha);
    wr(ADDR_ACC, 32'h55);
    i_mem.mem[12'h020] = 8'hff;
    op({OPC_INC_SKIP_NZ, 2'b00, 8'h20}, 1'b1, 1, 0);
    chk("acc", 8'h00, accumulator);
    chk("mem", 8'hff, i_mem.mem[12'h020]);
    chk("flags", 2'b10, {flag_negative, flag_zero});
    i_mem.mem[12'hf80] = 8'hff;
    op({OPC_INC_SKIP_Z, 2'b10, 8'h80}, 1'b1, 3, 1);
    chk("mem", 8'h00, i_mem.mem[12'hf80]);
    i_mem.mem[12'h310] = 8'h05;
    op({OPC_INC_SKIP_Z, 2'b01, 8'h10}, 1'b1, 1, 0);
    chk("acc", 8'h06, accumulator);
    wr(ADDR_CTRL, 32'h1);
    i_mem.mem[12'h205] = 8'h81;
    op({OPC_OR_FILE, 2'b00, 8'h05}, 1'b0, 1, 0);
    chk("acc", 8'h87, accumulator);
    chk("flags", 2'b10, {flag_negative, flag_zero});
    i_mem.mem[12'hf60] = 8'h10;
    op({OPC_OR_FILE, 2'b10, 8'h60}, 1'b0, 1, 0);
    chk("mem", 8'h97, i_mem.mem[12'hf60]);
    chk("acc", 8'h87, accumulator);
    i_mem.mem[12'h25f] = 8'h00;
    op({OPC_INC_SKIP_NZ, 2'b10, 8'h5f}, 1'b1, 3, 1);
    chk("mem", 8'h01, i_mem.mem[12'h25f]);
    wr(ADDR_ACC, 32'h9a);
    op({OPC_OR_LIT, 8'h35}, 1'b0, 1, 0);
    chk("acc", 8'hbf, accumulator);
    chk("flags", 2'b10, {flag_negative, flag_zero});
    wr(ADDR_ACC, 32'h0);
    op({OPC_OR_LIT, 8'h00}, 1'b0, 1, 0);
    chk("flags", 2'b01, {flag_negative, flag_zero});
    op(16'hffff, 1'b0, 1, 0);
    rchk(ADDR_STATUS, 32'h19, 1'b0);
    report_and_stop();
  end
endmodule // tb_inc_skip_or_exec
`default_nettype wire
